// file: core/acq_control.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module acq_control #(
   parameter int FAST_DIV = acq_pkg::FAST_CYC,
   parameter int SLOW_DIV = acq_pkg::SLOW_CYC
) (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rstn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // probe and system pins
   input  wire acq_pkg::probe_pins_t probe,
   input  wire logic                slow_card_trigger,
   input  wire logic                slow_card_sample_clock,
   input  wire logic [2:0]          expander_match_inputs,
   // acquisition outputs
   output logic [7:0]               phase_clocks,
   output logic [2:0]               expander_clock_outputs,
   output logic [1:0]               fine_resolution_selector_set,
   output logic                     address_wrap_flag,
   output logic                     halt_storage,
   output logic                     main_card_triggered_n
);
   // pin synchronisers, first stage read only by second
   logic [12:0] sync1;
   logic [12:0] sync2;
   logic        clk_prev;
   logic        card_prev;
   logic        strig_prev;
   // registers
   logic [7:0]  ctrl;
   logic [7:0]  wctl;
   logic [7:0]  csel;
   logic [14:0] delay_load;
   logic [7:0]  store_ctrl;
   logic [10:0] rb_ptr;
   // acquisition state
   logic [2:0]  phase;
   logic [7:0]  addr_cnt [4];
   logic [3:0]  mem [8][256];
   logic        sample_en;
   logic        step_pulse;
   logic        fast_tick;
   logic        slow_tick;
   logic [7:0]  fast_cnt;
   logic [7:0]  slow_cnt;
   logic        word_ff;
   logic        armed;
   logic        triggered;
   logic        running;
   logic        count_done;
   logic [14:0] delay_cnt;
   logic [1:0]  halt_cnt;
   logic [15:0] diff_cnt;
   logic        diff_run;
   // bus decode
   logic        wr_acc;
   logic        rd_setup;
   logic [3:0]  idx;
   logic        trig_clear;
   logic        store_control_strobe;
   logic        single_step_strobe;

   // unpack synced pins
   wire logic [7:0] s_data  = sync2[7:0];
   wire logic       s_pclk  = sync2[8];
   wire logic       s_ident = sync2[9];
   wire logic       s_att   = sync2[10];
   wire logic       s_card  = sync2[11];
   wire logic       s_strig = sync2[12];

   // expander matches have their own two-stage chain
   logic [2:0] m1;
   logic [2:0] m2;

   // decode an apb index from a byte address
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      reg_index = a[5:2];
   endfunction

   // two flip-flop synchronisers for all pins
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1 <= 13'h0000;
         sync2 <= 13'h0000;
         m1    <= 3'h0;
         m2    <= 3'h0;
      end else begin
         sync1 <= {slow_card_trigger, slow_card_sample_clock, probe.attached_n,
                   probe.ident_n, probe.clk, probe.data};
         sync2 <= sync1;
         m1    <= expander_match_inputs;
         m2    <= m1;
      end
   end

   // apb: zero wait, read data captured in setup, write data in access
   assign idx     = reg_index(paddr);
   assign wr_acc  = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   // store control needs write, port, slot active and no read
   assign store_control_strobe = wr_acc & (idx == acq_pkg::IDX_STORE);
   assign single_step_strobe   = wr_acc & (idx == acq_pkg::IDX_STEP);
   assign trig_clear = ~rstn ? 1'b0 :
                       (wr_acc & (idx == acq_pkg::IDX_CTRL) & pwdata[acq_pkg::CTRL_CLEAR]);

   // writable registers, cleared by buffered reset, except ctrl, which loads CTRL_RST
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl       <= acq_pkg::CTRL_RST;
         wctl       <= acq_pkg::ZERO8;
         csel       <= acq_pkg::ZERO8;
         delay_load <= 15'h0000;
         store_ctrl <= acq_pkg::ZERO8;
         rb_ptr     <= 11'h000;
      end else if (wr_acc) begin
         case (idx)
            acq_pkg::IDX_CTRL:  ctrl       <= pwdata[7:0];
            acq_pkg::IDX_WCTL:  wctl       <= pwdata[7:0];
            acq_pkg::IDX_CSEL:  csel       <= pwdata[7:0];
            acq_pkg::IDX_DELAY: delay_load <= pwdata[14:0];
            acq_pkg::IDX_STORE: store_ctrl <= pwdata[7:0];
            acq_pkg::IDX_RBPTR: rb_ptr     <= pwdata[10:0];
            default:            ctrl       <= ctrl;
         endcase
      end
   end

   // read data, captured in setup phase
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         case (idx)
            acq_pkg::IDX_CTRL:  prdata[7:0]  <= ctrl;
            acq_pkg::IDX_WCTL:  prdata[7:0]  <= wctl;
            acq_pkg::IDX_CSEL:  prdata[7:0]  <= csel;
            acq_pkg::IDX_DELAY: prdata[14:0] <= delay_load;
            acq_pkg::IDX_STORE: prdata[7:0]  <= store_ctrl;
            acq_pkg::IDX_RBPTR: prdata[10:0] <= rb_ptr;
            acq_pkg::IDX_DIFF:  prdata[15:0] <= diff_cnt;
            acq_pkg::IDX_STAT: begin
               prdata[acq_pkg::STAT_WRAP] <= address_wrap_flag;
               prdata[acq_pkg::STAT_TRIG] <= triggered;
               prdata[acq_pkg::STAT_RUN]  <= running;
               prdata[acq_pkg::STAT_DONE] <= count_done;
            end
            acq_pkg::IDX_POD: begin
               prdata[acq_pkg::POD_ATTACH] <= s_att;
               prdata[acq_pkg::POD_IDENT]  <= s_ident;
            end
            acq_pkg::IDX_RBACK: begin
               // memory data or counter contents
               if (store_ctrl[acq_pkg::ST_MEM_SEL])
                  prdata[3:0] <= mem[rb_ptr[10:8]][rb_ptr[7:0]];
               else
                  prdata[7:0] <= addr_cnt[rb_ptr[10:9]];
            end
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // oscillators run only while their enable is set
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fast_cnt  <= 8'h00;
         slow_cnt  <= 8'h00;
         fast_tick <= 1'b0;
         slow_tick <= 1'b0;
      end else begin
         fast_tick <= 1'b0;
         slow_tick <= 1'b0;
         if (!store_ctrl[acq_pkg::ST_FAST_EN]) begin
            fast_cnt <= 8'h00;
         end else if (fast_cnt == 8'(FAST_DIV - 1)) begin
            fast_cnt  <= 8'h00;
            fast_tick <= 1'b1;
         end else begin
            fast_cnt <= fast_cnt + 8'h01;
         end
         if (!store_ctrl[acq_pkg::ST_SLOW_EN]) begin
            slow_cnt <= 8'h00;
         end else if (slow_cnt == 8'(SLOW_DIV - 1)) begin
            slow_cnt  <= 8'h00;
            slow_tick <= 1'b1;
         end else begin
            slow_cnt <= slow_cnt + 8'h01;
         end
      end
   end

   // edge history of synced clock and trigger pins
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         clk_prev   <= 1'b0;
         card_prev  <= 1'b0;
         strig_prev <= 1'b0;
      end else begin
         clk_prev   <= s_pclk;
         card_prev  <= s_card;
         strig_prev <= s_strig;
      end
   end

   // single step needs strobe and enable
   assign step_pulse = single_step_strobe & store_ctrl[acq_pkg::ST_STEP_EN];

   // sample clock select, gated by launch and halt state
   always_comb begin
      logic src_ev;
      src_ev = 1'b0;
      case (acq_pkg::clk_src_t'(csel[acq_pkg::CS_SRC_LO +: 3]))
         acq_pkg::SRC_PROBE: src_ev = (csel[acq_pkg::CS_RISE] & s_pclk & ~clk_prev)
                                   | (csel[acq_pkg::CS_FALL] & ~s_pclk & clk_prev);
         acq_pkg::SRC_FAST:  src_ev = fast_tick;
         acq_pkg::SRC_SLOW:  src_ev = slow_tick;
         acq_pkg::SRC_CARD:  src_ev = s_card & ~card_prev;
         acq_pkg::SRC_STEP:  src_ev = 1'b0;
         default:            src_ev = 1'b0;
      endcase
      sample_en = running & (step_pulse |
                  (store_ctrl[acq_pkg::ST_LAUNCH] & src_ev));
   end

   // eight-phase generator and expander clocks
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase                  <= 3'h0;
         phase_clocks           <= 8'h00;
         expander_clock_outputs <= 3'h0;
      end else begin
         phase_clocks           <= sample_en ? (8'h01 << phase) : 8'h00;
         expander_clock_outputs <= {3{sample_en}};
         if (trig_clear)
            phase <= 3'h0;
         else if (sample_en)
            phase <= phase + 3'h1;
      end
   end

   // latches, banks and address counters
   always_ff @(posedge clk_sys) begin
      if (sample_en)
         mem[phase][addr_cnt[phase[2:1]]] <= s_data[3:0];
   end

   // counter pairs step after their second phase
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++)
            addr_cnt[i] <= 8'h00;
         address_wrap_flag <= 1'b0;
      end else if (trig_clear) begin
         address_wrap_flag <= 1'b0;
      end else if (sample_en && phase[0]) begin
         addr_cnt[phase[2:1]] <= addr_cnt[phase[2:1]] + 8'h01;
         if (phase[2:1] == 2'h0 && addr_cnt[0] == 8'hFF)
            address_wrap_flag <= 1'b1;
      end
   end

   // word recognizer flip-flop with mask and pattern
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         word_ff <= 1'b1;
      end else if (trig_clear) begin
         word_ff <= 1'b1;
      end else if (sample_en) begin
         word_ff <= (&((s_data[3:0] ~^ wctl[7:4]) | wctl[3:0]))
                    & (&m2);
      end
   end

   // arming, trigger and run control
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         armed     <= 1'b0;
         triggered <= 1'b0;
         running   <= 1'b1;
         halt_cnt  <= 2'h0;
      end else if (trig_clear) begin
         armed     <= 1'b0;
         triggered <= 1'b0;
         running   <= 1'b1;
         halt_cnt  <= 2'h0;
      end else begin
         if ((s_strig & ~strig_prev) | ctrl[acq_pkg::CTRL_ARM])
            armed <= 1'b1;
         if (armed && word_ff && sample_en && !store_ctrl[acq_pkg::ST_PRESET])
            triggered <= 1'b1;
         if (halt_storage && sample_en) begin
            halt_cnt <= halt_cnt + 2'h1;
            if (halt_cnt == 2'(acq_pkg::HALT_EXTRA - 1))
               running <= 1'b0;
         end
      end
   end

   // post-trigger delay counter
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         delay_cnt  <= 15'h0000;
         count_done <= 1'b0;
      end else if (trig_clear || !triggered) begin
         delay_cnt  <= delay_load;
         count_done <= 1'b0;
      end else if (sample_en && !count_done) begin
         if (delay_cnt == 15'h0000)
            count_done <= 1'b1;
         else
            delay_cnt <= delay_cnt - 15'h0001;
      end
   end

   // difference counter on slow-card clock
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         diff_cnt <= 16'h0000;
         diff_run <= 1'b0;
      end else if (s_strig & ~strig_prev) begin
         diff_cnt <= 16'h0000;
         diff_run <= 1'b1;
      end else if (triggered) begin
         diff_run <= 1'b0;
      end else if (diff_run && s_card && !card_prev) begin
         diff_cnt <= diff_cnt + 16'h0001;
      end
   end

   // status outputs and selector set lines
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fine_resolution_selector_set <= 2'h0;
      end else if (store_ctrl[acq_pkg::ST_PRESET] || trig_clear) begin
         fine_resolution_selector_set <= 2'h3;
      end else begin
         fine_resolution_selector_set <= {2{ctrl[acq_pkg::CTRL_FINE_N]}};
      end
   end
   assign halt_storage          = count_done;
   assign main_card_triggered_n = ~triggered;

   // wrap flag follows counter 0 roll
   wrap_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sample_en && phase == 3'h1 && addr_cnt[0] == 8'hFF && !trig_clear)
      |=> address_wrap_flag) else $error("wrap flag missed");
   // readback of counters when memory select low
   readback_src_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rd_setup && idx == acq_pkg::IDX_RBACK && !store_ctrl[acq_pkg::ST_MEM_SEL]
       && !sample_en) |=> prdata[7:0] == $past(addr_cnt[rb_ptr[10:9]]))
      else $error("readback source wrong");
   // store control only on its index
   store_dec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      store_control_strobe |-> (pwrite && psel && penable && paddr[5:2] == 4'hD))
      else $error("store strobe decode");
   // enabled single step while running gives a sample
   step_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (single_step_strobe && store_ctrl[acq_pkg::ST_STEP_EN] && running)
      |=> phase_clocks != 8'h00) else $error("step without sample");
   // halt tracks done
   done_halt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(count_done) |-> halt_storage && $past(delay_cnt) == 15'h0000)
      else $error("done without terminal");
   // run stops after three samples
   halt_three_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(running) |-> $past(halt_cnt) == 2'h2 && halt_storage)
      else $error("halt count wrong");
   // selectors low in fine mode
   fine_sel_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!ctrl[acq_pkg::CTRL_FINE_N] && !store_ctrl[acq_pkg::ST_PRESET] && !trig_clear)
      |=> fine_resolution_selector_set == 2'h0) else $error("fine select wrong");
   // phase clock one hot per sample
   phase_hot_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      sample_en |=> $onehot(phase_clocks) && expander_clock_outputs == 3'h7)
      else $error("phase clock wrong");
   // no fast oscillator tick while disabled
   osc_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !store_ctrl[acq_pkg::ST_FAST_EN] |=> !fast_tick) else $error("osc ran disabled");
   // main scenarios
   trig_c: cover property (@(posedge clk_sys) $rose(triggered));
   wrap_c: cover property (@(posedge clk_sys) $rose(address_wrap_flag));
   stop_c: cover property (@(posedge clk_sys) $fell(running));
endmodule
`default_nettype wire

// file: include/acq_pkg.sv
// Functional notes
// - wrap flag rises when first counters roll
// - readback: memory data or counter contents
// - store control strobe on index D write
// - single step from strobe and enable
// - probe attached is pod status bit 6
// - identify button is pod status bit 2
// - port select gates decoder and reads
// - terminal count: done bit 6, halt storage
// - halt stops counter, three more samples
// - trigger stops difference, starts delay count
// - slow trigger starts difference, arms trigger
// - mask bits make recognizer bits don't care
// - pattern bits in upper write control nibble
// - three expander matches, three clock outputs
// - fine resolution low drives selectors low
// - all phases 0-7 latch the low half, data bits 3-0
// - bank pairs addressed by own counter
// - clock source bits 4-6, edge bits 4-5
// - oscillators run only while enabled
// - launch passes clock, preset holds selectors
// - reset and trigger clear initialise state
package acq_pkg;
   // register indexes, byte address is four times the index
   localparam logic [3:0] IDX_CTRL  = 4'h0;
   localparam logic [3:0] IDX_WCTL  = 4'h1;
   localparam logic [3:0] IDX_CSEL  = 4'h2;
   localparam logic [3:0] IDX_DELAY = 4'h3;
   localparam logic [3:0] IDX_STEP  = 4'h4;
   localparam logic [3:0] IDX_STAT  = 4'h5;
   localparam logic [3:0] IDX_POD   = 4'h6;
   localparam logic [3:0] IDX_RBACK = 4'h7;
   localparam logic [3:0] IDX_RBPTR = 4'h8;
   localparam logic [3:0] IDX_DIFF  = 4'h9;
   localparam logic [3:0] IDX_STORE = 4'hD;
   // control register fields
   localparam int CTRL_FINE_N  = 0;
   localparam int CTRL_CLEAR   = 1;
   localparam int CTRL_ARM     = 2;
   // store control register fields
   localparam int ST_LAUNCH    = 0;
   localparam int ST_STEP_EN   = 1;
   localparam int ST_FAST_EN   = 2;
   localparam int ST_SLOW_EN   = 3;
   localparam int ST_MEM_SEL   = 4;
   localparam int ST_PRESET    = 5;
   // clock select fields
   localparam int CS_SRC_LO    = 4;
   localparam int CS_RISE      = 4;
   localparam int CS_FALL      = 5;
   // status and pod status bit positions
   localparam int STAT_WRAP    = 0;
   localparam int STAT_TRIG    = 1;
   localparam int STAT_RUN     = 2;
   localparam int STAT_DONE    = 6;
   localparam int POD_IDENT    = 2;
   localparam int POD_ATTACH   = 6;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [7:0] ZERO8    = 8'h00;
   // sample clock sources
   typedef enum logic [2:0] {
      SRC_PROBE, SRC_FAST, SRC_SLOW, SRC_CARD, SRC_STEP
   } clk_src_t;
   // oscillator periods and system clock
   localparam int CLK_NS      = 40;
   localparam int FAST_OSC_NS = 3;
   localparam int SLOW_OSC_NS = 5;
   localparam int FAST_CYC = (FAST_OSC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOW_CYC = (SLOW_OSC_NS + CLK_NS - 1) / CLK_NS;
   localparam int HALT_EXTRA   = 3;
   // probe pins travel together
   typedef struct packed {
      logic       attached_n;
      logic       ident_n;
      logic       clk;
      logic [7:0] data;
   } probe_pins_t;
endpackage

// file: verification/far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
   // clock
   input  wire logic            clk_sys,
   // levels asked for by the bench
   input  wire logic            attached_n,
   input  wire logic            ident_n,
   input  wire logic [7:0]      data,
   input  wire logic            slow_run,
   // pins into the block
   output acq_pkg::probe_pins_t probe,
   output logic                 slow_card_sample_clock
);
   logic [1:0] div; // slow clock divider

   // probe clock idles low, the levels follow the bench
   assign probe = '{attached_n: attached_n, ident_n: ident_n, clk: 1'b0, data: data};

   // slow clock runs only while asked, stands low otherwise
   always_ff @(posedge clk_sys) begin
      div <= slow_run ? div + 2'h1 : 2'h0;
      slow_card_sample_clock <= slow_run & div[1];
   end
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic                 clk_sys = 1'b0;
   logic                 rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]           paddr, pdata, phase_clocks;
   logic [31:0]          pwdata, prdata;
   acq_pkg::probe_pins_t probe;
   logic                 slow_trig, slow_clk, slow_run, att_n, id_n, sck_q;
   logic [2:0]           match, ex_clk;
   logic [1:0]           sel_set;
   logic                 wrap, halt, trig_n;
   int                   n_errors, n_checks, n_smp, n_p1, n_sck;

   always #20 clk_sys = ~clk_sys;

   acq_control #(.FAST_DIV(1), .SLOW_DIV(1)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .probe(probe), .slow_card_trigger(slow_trig), .slow_card_sample_clock(slow_clk),
      .expander_match_inputs(match), .phase_clocks(phase_clocks),
      .expander_clock_outputs(ex_clk), .fine_resolution_selector_set(sel_set),
      .address_wrap_flag(wrap), .halt_storage(halt), .main_card_triggered_n(trig_n));

   far_side_model partner (.clk_sys(clk_sys), .attached_n(att_n), .ident_n(id_n),
      .data(pdata), .slow_run(slow_run), .probe(probe), .slow_card_sample_clock(slow_clk));

   // counts samples and slow clock edges on the settled half cycle
   always @(negedge clk_sys) begin
      if (phase_clocks !== 8'h00) n_smp++;
      if (phase_clocks[1] === 1'b1) n_p1++;
      if (slow_clk === 1'b1 && sck_q === 1'b0) n_sck++;
      sck_q = slow_clk;
   end

   // one compare for every result
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] x;
      apb(1'b1, idx, d, x);
   endtask

   // read, keep upper bits and masked low bits, compare
   task automatic rdc(input string what, input logic [3:0] idx, input logic [7:0] msk,
                      input logic [7:0] exp);
      logic [31:0] x;
      apb(1'b0, idx, 8'h00, x);
      chk(what, {24'h000000, exp}, x & {24'hFFFFFF, msk});
   endtask

   // first sample pulse within ten cycles, zero if none
   task automatic next_pulse(output logic [7:0] pc, output logic [2:0] ec);
      pc = 8'h00;
      ec = 3'h0;
      for (int i = 0; i < 10 && pc === 8'h00; i++) begin
         @(negedge clk_sys);
         pc = phase_clocks;
         ec = ex_clk;
      end
   endtask

   task automatic t_reset();
      chk("selector set", 32'h3, {30'h0, sel_set});
      chk("ready", 32'h1, {31'h0, pready});
      chk("no error", 32'h0, {31'h0, pslverr});
      rdc("status", acq_pkg::IDX_STAT, 8'h43, 8'h00);
      rdc("unmapped", 4'hF, 8'hFF, 8'h00);
   endtask

   task automatic t_pod();
      att_n <= 1'b0;
      id_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdc("pod attached", acq_pkg::IDX_POD, 8'h44, 8'h04);
      att_n <= 1'b1;
      id_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rdc("pod button", acq_pkg::IDX_POD, 8'h44, 8'h40);
   endtask

   task automatic t_fine();
      wr(acq_pkg::IDX_CTRL, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk("fine selectors", 32'h0, {30'h0, sel_set});
      wr(acq_pkg::IDX_CTRL, 8'h01);
      repeat (3) @(posedge clk_sys);
      chk("normal selectors", 32'h3, {30'h0, sel_set});
   endtask

   task automatic t_wrap();
      int n0;
      wr(acq_pkg::IDX_CTRL, 8'h03);
      wr(acq_pkg::IDX_CSEL, 8'h10);
      n_p1 = 0;
      wr(acq_pkg::IDX_STORE, 8'h05);
      for (int i = 0; i < 2200 && wrap !== 1'b1; i++) @(negedge clk_sys);
      @(posedge clk_sys);
      chk("samples at wrap", 32'd256, n_p1);
      rdc("wrap status", acq_pkg::IDX_STAT, 8'h01, 8'h01);
      wr(acq_pkg::IDX_STORE, 8'h01);
      repeat (3) @(posedge clk_sys);
      n0 = n_smp;
      repeat (10) @(posedge clk_sys);
      chk("oscillator off", 32'd0, n_smp - n0);
      rdc("counter readback", acq_pkg::IDX_RBACK, 8'hFF, n_p1[7:0]);
   endtask

   task automatic t_step();
      logic [7:0] pc;
      logic [2:0] ec;
      logic [7:0] a0;
      a0 = n_p1[7:0];
      pdata <= 8'h09;
      wr(acq_pkg::IDX_CTRL, 8'h03);
      wr(acq_pkg::IDX_STORE, 8'h02);
      wr(acq_pkg::IDX_STEP, 8'h00);
      next_pulse(pc, ec);
      chk("first phase", 32'h01, {24'h0, pc});
      chk("expander clocks", 32'h7, {29'h0, ec});
      wr(acq_pkg::IDX_STEP, 8'h00);
      next_pulse(pc, ec);
      chk("second phase", 32'h02, {24'h0, pc});
      wr(acq_pkg::IDX_STORE, 8'h00);
      wr(acq_pkg::IDX_STEP, 8'h00);
      next_pulse(pc, ec);
      chk("step disabled", 32'h00, {24'h0, pc});
      wr(acq_pkg::IDX_RBPTR, a0);
      wr(acq_pkg::IDX_STORE, 8'h10);
      rdc("memory readback", acq_pkg::IDX_RBACK, 8'h0F, 8'h09);
   endtask

   task automatic t_diff();
      wr(acq_pkg::IDX_CTRL, 8'h03);
      slow_trig <= 1'b1;
      repeat (6) @(posedge clk_sys);
      n_sck = 0;
      slow_run <= 1'b1;
      repeat (40) @(posedge clk_sys);
      slow_run <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rdc("difference", acq_pkg::IDX_DIFF, 8'hFF, n_sck[7:0]);
      slow_trig <= 1'b0;
   endtask

   task automatic t_trig();
      int n0;
      pdata <= 8'h0A;
      match <= 3'h7;
      wr(acq_pkg::IDX_CTRL, 8'h03);
      wr(acq_pkg::IDX_WCTL, 8'h80);
      wr(acq_pkg::IDX_DELAY, 8'h04);
      wr(acq_pkg::IDX_CTRL, 8'h05);
      wr(acq_pkg::IDX_STORE, 8'h25);
      wr(acq_pkg::IDX_STORE, 8'h05);
      chk("preset blocks", 32'h1, {31'h0, trig_n});
      repeat (30) @(posedge clk_sys);
      chk("pattern mismatch", 32'h1, {31'h0, trig_n});
      match <= 3'h6;
      wr(acq_pkg::IDX_WCTL, 8'h83);
      repeat (30) @(posedge clk_sys);
      chk("expander blocks", 32'h1, {31'h0, trig_n});
      match <= 3'h7;
      for (int i = 0; i < 30 && trig_n !== 1'b0; i++) @(negedge clk_sys);
      chk("masked match", 32'h0, {31'h0, trig_n});
      for (int i = 0; i < 60 && halt !== 1'b1; i++) @(negedge clk_sys);
      chk("halt", 32'h1, {31'h0, halt});
      @(posedge clk_sys);
      n0 = n_smp;
      repeat (30) @(negedge clk_sys);
      chk("samples after halt", 32'd3, n_smp - n0);
      rdc("done status", acq_pkg::IDX_STAT, 8'h42, 8'h42);
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end

   // main sequence
   initial begin
      {n_errors, n_checks, n_smp, n_p1, n_sck} = '0;
      {rstn, psel, penable, pwrite, slow_trig, slow_run, sck_q} = '0;
      {paddr, pwdata, pdata, match} = '0;
      att_n = 1'b1;
      id_n = 1'b1;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_pod();
      t_fine();
      t_wrap();
      t_step();
      t_diff();
      t_trig();
      summarize();
   end
endmodule
`default_nettype wire
